// *** hw/dlw_top.sv ***
// DLL mode, self refresh exit and write leveling control of the die.
// Assumes decoded command strobes and pad samples synchronous to clk_i,
// and a classic Wishbone master standing in for the mode register path.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module dlw_top
   import dlw_pkg::*;
#(
   parameter int unsigned LANES    = 2,
   parameter int unsigned LANE_W   = 8,
   parameter int unsigned LOCK_CYC = DLLK_CYC
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [31:0]              wb_dat_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic                     wb_we_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // Decoded commands and pad samples
   input  wire dlw_cmd_t                 cmd_i,
   input  wire logic                     odt_i,
   input  wire logic                     ck_level_i,
   input  wire logic [LANES-1:0]         dqs_rise_i,
   // Pad side outputs
   output logic [LANES*LANE_W-1:0]       dq_o,
   output logic [LANES*LANE_W-1:0]       dq_oe_o,
   output dlw_term_t                     term_o,
   output logic                          rd_strobe_start_o,
   // Status
   output logic                          dll_locked_o,
   output logic                          cmd_ready_o
);

   localparam int unsigned XC_W = $clog2(XS_CYC + XS_ABORT_CYC + RFC_CYC + 1);
   localparam logic [XC_W-1:0] XS_LAST    = XC_W'(XS_CYC - 1);
   localparam logic [XC_W-1:0] XSA_LAST   = XC_W'(XS_ABORT_CYC - 1);
   localparam logic [XC_W-1:0] RFC_LAST   = XC_W'(RFC_CYC - 1);

   // Mode register shadows
   logic [4:0]        cl_reg;
   logic [4:0]        cwl_reg;
   logic [1:0]        al_reg;
   logic              dll_en_reg;
   logic              wl_en_reg;
   logic [2:0]        rtt_nom_reg;
   logic              qoff_reg;
   logic              sr_abort_reg;
   logic              dll_rst_pulse_reg;
   // Power state and timers
   dlw_state_t        state_reg;
   dlw_state_t        state_next;
   logic [XC_W-1:0]   xs_cnt_reg;
   logic [XC_W-1:0]   rfc_cnt_reg;
   logic              rfc_busy_reg;
   logic [15:0]       ref_count_reg;
   logic              rtt_at_entry_reg;
   // Read path
   logic [RD_PIPE_LEN-1:0] rd_pipe_reg;
   logic [5:0]        rd_lat;
   logic              cfg_off_ok;
   // Bus decode
   logic              wb_req;
   logic              wb_wr;
   logic [31:0]       status_word;
   logic [31:0]       rd_word;
   logic              dll_locked;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;

   // One-cycle acknowledge; unmapped addresses are acked and read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // MR0: CAS latency and the self-clearing DLL reset bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cl_reg            <= CL_RST;
         dll_rst_pulse_reg <= 1'b0;
      end else begin
         dll_rst_pulse_reg <= 1'b0;
         if (wb_wr && wb_adr_i == MR0_OFS) begin
            if (wb_sel_i[0]) begin
               cl_reg <= wb_dat_i[MR0_CL_LSB +: 5];
            end
            if (wb_sel_i[1]) begin
               dll_rst_pulse_reg <= wb_dat_i[MR0_DLL_RST];
            end
         end
      end
   end

   // MR1: DLL enable, additive latency, leveling, termination, Qoff
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dll_en_reg  <= DLL_EN_RST;
         al_reg      <= 2'h0;
         wl_en_reg   <= 1'b0;
         rtt_nom_reg <= 3'h0;
         qoff_reg    <= 1'b0;
      end else if (wb_wr && wb_adr_i == MR1_OFS) begin
         if (wb_sel_i[0]) begin
            dll_en_reg <= wb_dat_i[MR1_DLL_EN];
            al_reg     <= wb_dat_i[MR1_AL_LSB +: 2];
            wl_en_reg  <= wb_dat_i[MR1_WL_EN];
         end
         if (wb_sel_i[1]) begin
            rtt_nom_reg <= wb_dat_i[MR1_RTTNOM_LSB +: 3];
            qoff_reg    <= wb_dat_i[MR1_QOFF];
         end
      end
   end

   // MR2 write latency and MR4 self refresh abort
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cwl_reg      <= CWL_RST;
         sr_abort_reg <= 1'b0;
      end else begin
         if (wb_wr && wb_adr_i == MR2_OFS && wb_sel_i[0]) begin
            cwl_reg <= wb_dat_i[MR2_CWL_LSB +: 5];
         end
         if (wb_wr && wb_adr_i == MR4_OFS && wb_sel_i[1]) begin
            sr_abort_reg <= wb_dat_i[MR4_SR_ABORT];
         end
      end
   end

   // DLL lock timing; a disabled DLL drops lock at once
   dlw_lock_timer #(
      .LOCK_CYC (LOCK_CYC)
   ) u_lock (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .enable_i  (dll_en_reg),
      .restart_i (dll_rst_pulse_reg),
      .locked_o  (dll_locked)
   );

   assign dll_locked_o = dll_locked;

   // Power state sequencing; commands outside their state are ignored
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_i.sr_enter) begin
               state_next = ST_SREF;
            end else if (cmd_i.pd_enter) begin
               state_next = ST_PDOWN;
            end
         end
         ST_SREF: begin
            if (cmd_i.sr_exit) begin
               state_next = ST_XWAIT;
            end
         end
         ST_XWAIT: begin
            if (xs_cnt_reg == '0) begin
               state_next = ST_IDLE;
            end
         end
         ST_PDOWN: begin
            if (cmd_i.pd_exit) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Exit wait chosen by the abort bit at the moment of exit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xs_cnt_reg <= '0;
      end else if (state_reg == ST_SREF && cmd_i.sr_exit) begin
         xs_cnt_reg <= sr_abort_reg ? XSA_LAST : XS_LAST;
      end else if (xs_cnt_reg != '0) begin
         xs_cnt_reg <= xs_cnt_reg - 1'b1;
      end
   end

   // Refresh in idle or self refresh; abort drops it uncounted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rfc_busy_reg  <= 1'b0;
         rfc_cnt_reg   <= '0;
         ref_count_reg <= 16'h0000;
      end else if (state_reg == ST_SREF && cmd_i.sr_exit && sr_abort_reg) begin
         rfc_busy_reg <= 1'b0;
         rfc_cnt_reg  <= '0;
      end else if (rfc_busy_reg) begin
         if (rfc_cnt_reg == '0) begin
            rfc_busy_reg  <= 1'b0;
            ref_count_reg <= ref_count_reg + 16'h0001;
         end else begin
            rfc_cnt_reg <= rfc_cnt_reg - 1'b1;
         end
      end else if (cmd_i.refresh &&
                   (state_reg == ST_SREF || state_reg == ST_IDLE)) begin
         rfc_busy_reg <= 1'b1;
         rfc_cnt_reg  <= RFC_LAST;
      end
   end

   // Remember whether nominal termination was on when power-down began
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rtt_at_entry_reg <= 1'b0;
      end else if (state_reg == ST_IDLE &&
                   (cmd_i.sr_enter || cmd_i.pd_enter)) begin
         rtt_at_entry_reg <= (rtt_nom_reg != 3'h0);
      end
   end

   // Termination: leveling steers strobe only; no nominal termination in SR or if disabled
   always_comb begin
      term_o.dqs_term = wl_en_reg && odt_i;
      term_o.rtt_nom  = !wl_en_reg && odt_i &&
                        (rtt_nom_reg != 3'h0) &&
                        state_reg != ST_SREF &&
                        state_reg != ST_XWAIT &&
                        !(state_reg == ST_PDOWN &&
                          !rtt_at_entry_reg);
   end

   // Read strobe timing one cycle earlier with the DLL off
   assign rd_lat = 6'({1'b0, cl_reg} + {4'h0, al_reg}) -
                   6'(!dll_en_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_pipe_reg <= '0;
      end else begin
         rd_pipe_reg <= {rd_pipe_reg[RD_PIPE_LEN-2:0],
                         cmd_i.read && !wl_en_reg};
      end
   end

   // Latency zero is not a legal setting, so it never fires
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_strobe_start_o <= 1'b0;
      end else begin
         rd_strobe_start_o <= (rd_lat != 6'h00) &&
                              rd_pipe_reg[rd_lat - 6'h01];
      end
   end

   // Latency pairing check for DLL-off operation
   assign cfg_off_ok = dll_en_reg ||
                       (cl_reg == CL_DLL_OFF &&
                        cwl_reg == CWL_DLL_OFF);

   // Leveling feedback: each lane samples CK on its own strobe edge
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (rst_i || !wl_en_reg) begin
               dq_o[g*LANE_W +: LANE_W] <= '0;
            end else if (dqs_rise_i[g]) begin
               dq_o[g*LANE_W +: LANE_W] <= {LANE_W{ck_level_i}};
            end
         end
         // Buffers drive only while leveling and not switched off
         assign dq_oe_o[g*LANE_W +: LANE_W] =
            {LANE_W{wl_en_reg && !qoff_reg}};
      end
   endgenerate

   // Status word: DLL, leveling, state and configuration flags
   assign status_word = {22'h0, cfg_off_ok, rfc_busy_reg, state_reg,
                         rtt_at_entry_reg, qoff_reg, wl_en_reg,
                         cmd_ready_o, dll_locked, dll_en_reg};

   // Ready for commands once idle and the exit wait has run out
   assign cmd_ready_o = (state_reg == ST_IDLE);

   // Read multiplexer
   always_comb begin
      case (wb_adr_i)
         MR0_OFS:    rd_word = {27'h0, cl_reg};
         MR1_OFS:    rd_word = {19'h0, qoff_reg, 1'b0, rtt_nom_reg,
                                wl_en_reg, 2'h0, al_reg, 2'h0, dll_en_reg};
         MR2_OFS:    rd_word = {27'h0, cwl_reg};
         MR4_OFS:    rd_word = {22'h0, sr_abort_reg, 9'h0};
         STATUS_OFS: rd_word = status_word;
         REFCNT_OFS: rd_word = {16'h0, ref_count_reg};
         default:    rd_word = 32'h0000_0000;
      endcase
   end

   // Read data registered with the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= rd_word;
      end
   end

endmodule

// *** pkg/dlw_pkg.sv ***
// Shared constants and types for the DLL mode and write leveling block.
// Assumes a 250 MHz core clock and a classic Wishbone register bus.
package dlw_pkg;

   // Clock rate used to turn times into cycles
   localparam int unsigned CLK_PERIOD_PS = 4000;

   // Register byte offsets
   localparam logic [7:0] MR0_OFS    = 8'h00;
   localparam logic [7:0] MR1_OFS    = 8'h04;
   localparam logic [7:0] MR2_OFS    = 8'h08;
   localparam logic [7:0] MR4_OFS    = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] REFCNT_OFS = 8'h14;

   // Field positions inside the mode registers
   localparam int unsigned MR0_CL_LSB     = 0;
   localparam int unsigned MR0_DLL_RST    = 8;
   localparam int unsigned MR1_DLL_EN     = 0;
   localparam int unsigned MR1_AL_LSB     = 3;
   localparam int unsigned MR1_WL_EN      = 7;
   localparam int unsigned MR1_RTTNOM_LSB = 8;
   localparam int unsigned MR1_QOFF       = 12;
   localparam int unsigned MR2_CWL_LSB    = 0;
   localparam int unsigned MR4_SR_ABORT   = 9;

   // Values after reset
   localparam logic [4:0] CL_RST  = 5'h0A;
   localparam logic [4:0] CWL_RST = 5'h09;
   localparam logic       DLL_EN_RST = 1'b1;

   // The one latency pairing honoured while the DLL is off
   localparam logic [4:0] CL_DLL_OFF  = 5'h0A;
   localparam logic [4:0] CWL_DLL_OFF = 5'h09;

   // Exit and refresh times in ns, with derived cycle counts
   localparam int unsigned T_XS_NS       = 360;
   localparam int unsigned T_XS_ABORT_NS = 170;
   localparam int unsigned T_RFC_NS      = 350;
   localparam int unsigned XS_CYC =
      (T_XS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned XS_ABORT_CYC =
      (T_XS_ABORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RFC_CYC =
      (T_RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // DLL lock time in clock cycles
   localparam int unsigned DLLK_CYC = 597;

   // Depth of the read command delay line
   localparam int unsigned RD_PIPE_LEN = 64;

   // Power state machine, Gray coded along idle -> sref -> exit
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SREF  = 2'b01,
      ST_XWAIT = 2'b11,
      ST_PDOWN = 2'b10
   } dlw_state_t;

   // Decoded command strobes, one cycle each
   typedef struct packed {
      logic sr_enter;
      logic sr_exit;
      logic refresh;
      logic pd_enter;
      logic pd_exit;
      logic read;
   } dlw_cmd_t;

   // Termination controls towards the pads
   typedef struct packed {
      logic dqs_term;
      logic rtt_nom;
   } dlw_term_t;

endpackage

// *** hw/dlw_lock_timer.sv ***
// DLL lock timer: counts the lock time after each DLL reset.
// Assumes restart is a one-cycle pulse and enable follows the DLL bit.
`timescale 1ns/1ns
module dlw_lock_timer
   import dlw_pkg::*;
#(
   parameter int unsigned LOCK_CYC = DLLK_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic enable_i,
   input  wire logic restart_i,
   // Status
   output logic      locked_o
);

   localparam int unsigned CW = $clog2(LOCK_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(LOCK_CYC);

   logic [CW-1:0] cnt_reg;

   // A disabled DLL is never locked; a reset restarts the count
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i || restart_i) begin
         cnt_reg <= '0;
      end else if (cnt_reg != LAST) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign locked_o = enable_i && (cnt_reg == LAST);

endmodule

// *** testbench/dlw_monitor.sv ***
// Port checker for dlw_top, attached by bind at the foot of this file.
// Assumes AL stays 0 and mode bits change only over Wishbone writes.
`timescale 1ns/1ns
module dlw_monitor
   import dlw_pkg::*;
#(
   parameter int unsigned LANES    = 2,
   parameter int unsigned LANE_W   = 8,
   parameter int unsigned LOCK_CYC = DLLK_CYC
) (
   // Clock, reset and bus
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire logic [7:0]              wb_adr_i,
   input wire logic [31:0]             wb_dat_i,
   input wire logic [3:0]              wb_sel_i,
   input wire logic                    wb_we_i,
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_ack_o,
   // Pad side
   input wire dlw_cmd_t                cmd_i,
   input wire logic                    odt_i,
   input wire logic                    ck_level_i,
   input wire logic [LANES-1:0]        dqs_rise_i,
   input wire logic [LANES*LANE_W-1:0] dq_o,
   input wire logic [LANES*LANE_W-1:0] dq_oe_o,
   input wire dlw_term_t               term_o,
   // Status
   input wire logic                    rd_strobe_start_o,
   input wire logic                    dll_locked_o,
   input wire logic                    cmd_ready_o
);
   // Exit windows sized for the 250 MHz counts plus a small margin
   localparam int XN_LO = 78;
   localparam int XN_HI = 88;
   localparam int XA_LO = 32;
   localparam int XA_HI = 40;
   logic        wr;
   logic        wl_q;
   logic        qoff_q;
   logic        den_q;
   logic        ab_q;
   logic        in_sr;
   logic [4:0]  cl_q;
   logic [4:0]  lat;
   logic [31:0] rd_hist;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign lat = den_q ? cl_q : cl_q - 5'h01;
   // Shadow of the mode bits, updated on the edge the write is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wl_q <= 1'b0;
         qoff_q <= 1'b0;
         den_q <= DLL_EN_RST;
         ab_q <= 1'b0;
         cl_q <= CL_RST;
      end else if (wr) begin
         if (wb_adr_i == MR1_OFS && wb_sel_i[0]) begin
            wl_q <= wb_dat_i[MR1_WL_EN];
            den_q <= wb_dat_i[MR1_DLL_EN];
         end
         if (wb_adr_i == MR1_OFS && wb_sel_i[1]) begin
            qoff_q <= wb_dat_i[MR1_QOFF];
         end
         if (wb_adr_i == MR0_OFS && wb_sel_i[0]) begin
            cl_q <= wb_dat_i[4:0];
         end
         if (wb_adr_i == MR4_OFS && wb_sel_i[1]) begin
            ab_q <= wb_dat_i[MR4_SR_ABORT];
         end
      end
   end
   // History of accepted reads; leveling swallows them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_hist <= 32'h0;
      end else begin
         rd_hist <= {rd_hist[30:0], cmd_i.read & ~wl_q};
      end
   end
   // Self refresh flag, so a stray exit in power-down is not judged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_sr <= 1'b0;
      end else if (cmd_i.sr_enter && cmd_ready_o) begin
         in_sr <= 1'b1;
      end else if (cmd_i.sr_exit) begin
         in_sr <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_xs_norm;
      (!cmd_ready_o)[*8] ##[XN_LO:XN_HI] cmd_ready_o;
   endsequence
   sequence s_xs_abort;
      (!cmd_ready_o)[*8] ##[XA_LO:XA_HI] cmd_ready_o;
   endsequence
   sequence s_relock;
      ##2 (!dll_locked_o)[*8] ##[4:30] dll_locked_o;
   endsequence
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
   a_oe_mode: assert property (
      dq_oe_o == {(LANES*LANE_W){wl_q & ~qoff_q}})
      else $error("output enable off mode");
   a_lvl_term: assert property (wl_q |->
      !term_o.rtt_nom && term_o.dqs_term == odt_i)
      else $error("leveling termination wrong");
   a_lane_lo: assert property (wl_q && dqs_rise_i == 2'h1 |=>
      dq_o[7:0] == {8{$past(ck_level_i)}} && $stable(dq_o[15:8]))
      else $error("lower lane feedback wrong");
   a_lane_hi: assert property (wl_q && dqs_rise_i == 2'h2 |=>
      dq_o[15:8] == {8{$past(ck_level_i)}} && $stable(dq_o[7:0]))
      else $error("upper lane feedback wrong");
   a_read_lat: assert property (
      rd_strobe_start_o == rd_hist[lat]) else $error("read strobe late");
   a_dll_off: assert property ((!den_q)[*2] |-> !dll_locked_o)
      else $error("locked with DLL off");
   a_dll_relock: assert property (wr && wb_adr_i == MR0_OFS
      && wb_sel_i[1] && wb_dat_i[MR0_DLL_RST] && den_q |-> s_relock)
      else $error("DLL reset relock wrong");
   a_exit_norm: assert property (cmd_i.sr_exit && in_sr && !ab_q
      |=> s_xs_norm) else $error("normal exit time wrong");
   a_exit_abort: assert property (cmd_i.sr_exit && in_sr && ab_q
      |=> s_xs_abort) else $error("abort exit time wrong");
endmodule
bind dlw_top dlw_monitor #(
   .LANES    (LANES),
   .LANE_W   (LANE_W),
   .LOCK_CYC (LOCK_CYC)
) u_mon (.*);

// *** testbench/dlw_ctrl_model.sv ***
// Memory controller model: command pulses, ODT and leveling strobes.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module dlw_ctrl_model
   import dlw_pkg::*;
(
   // Clock
   input  wire logic clk_i,
   // Pins towards the die
   output dlw_cmd_t  cmd_o,
   output logic      odt_o,
   output logic      ck_o,
   output logic [1:0] dqs_o
);
   // ODT idles low so termination stays off around SR and power-down
   initial begin
      cmd_o = '0;
      odt_o = 1'b0;
      ck_o = 1'b0;
      dqs_o = 2'h0;
   end
   // Caller issues entry only from idle and waits out clock-stop time
   task automatic send(input dlw_cmd_t c);
      cmd_o <= c;
      @(posedge clk_i);
      cmd_o <= '0;
   endtask
   // One rising strobe on a lane while CK sits at the given level
   // An idle edge follows, so back-to-back calls never collide on dqs_o
   task automatic strobe(input int lane, input logic lvl);
      ck_o <= lvl;
      dqs_o <= 2'h1 << lane;
      @(posedge clk_i);
      dqs_o <= 2'h0;
      @(posedge clk_i);
   endtask
   // ODT level, kept here so the pin has one owner
   task automatic set_odt(input logic lvl);
      odt_o <= lvl;
   endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for dlw_top: Wishbone tasks and scenarios.
// Assumes the controller model drives commands, ODT, CK and strobes.
`timescale 1ns/1ns
module testbench
   import dlw_pkg::*;
;
   localparam dlw_cmd_t C_RD  = 6'h01;
   localparam dlw_cmd_t C_PDX = 6'h02;
   localparam dlw_cmd_t C_PDE = 6'h04;
   localparam dlw_cmd_t C_REF = 6'h08;
   localparam dlw_cmd_t C_SRX = 6'h10;
   localparam dlw_cmd_t C_SRE = 6'h20;
   logic        clk_i;
   logic        rst_i;
   logic        req;
   logic        we;
   logic        ack;
   logic        lk;
   logic        rdy;
   logic        rds;
   logic        odt;
   logic        ckl;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdo;
   logic [31:0] rdat;
   logic [15:0] dq;
   logic [15:0] oe;
   logic [1:0]  dqs;
   dlw_cmd_t    cmd;
   dlw_term_t   term;
   int          err_total;
   int          tests_run;
   dlw_top #(.LOCK_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
      .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(rdo), .wb_ack_o(ack),
      .cmd_i(cmd), .odt_i(odt), .ck_level_i(ckl), .dqs_rise_i(dqs),
      .dq_o(dq), .dq_oe_o(oe), .term_o(term), .rd_strobe_start_o(rds),
      .dll_locked_o(lk), .cmd_ready_o(rdy));
   dlw_ctrl_model mdl (.clk_i(clk_i), .cmd_o(cmd), .odt_o(odt),
      .ck_o(ckl), .dqs_o(dqs));
   // Comparisons are counted; mismatches print at once
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Classic cycle: hold until ack is seen at an edge, then release
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = rdo;
      req <= 1'b0;
      if (n >= 50) check(32'h0, 32'h1);
      @(posedge clk_i);
   endtask
   // Edges from the read edge to the strobe start pulse
   task automatic rd_lat(input logic [31:0] exp);
      int n;
      n = 0;
      mdl.send(C_RD);
      do begin
         @(posedge clk_i);
         n++;
      end while (rds !== 1'b1 && n < 60);
      check(n - 1, exp);
   endtask
   task automatic t_regs();
      wb(1'b1, 8'h1C, 4'hF, 32'h5A);
      wb(1'b0, 8'h1C, 4'hF, 32'h0);
      check(rdat, 32'h0);
      wb(1'b0, MR0_OFS, 4'hF, 32'h0);
      check(rdat & 32'h1F, {27'h0, CL_RST});
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
      check(rdat & 32'h7, 32'h5);
      tick(20);
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
      check(rdat & 32'h7, 32'h7);
   endtask
   task automatic t_dll();
      wb(1'b1, MR1_OFS, 4'h1, 32'h0);
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
      check(rdat & 32'h203, 32'h200);
      rd_lat(32'h9);
      wb(1'b1, MR1_OFS, 4'h1, 32'h1);
      wb(1'b1, MR0_OFS, 4'h3, 32'h10A);
      wb(1'b0, MR0_OFS, 4'hF, 32'h0);
      check(rdat & 32'h100, 32'h0);
      tick(30);
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
      check(rdat & 32'h3, 32'h3);
      rd_lat(32'hA);
   endtask
   task automatic sr_cycle(input logic ab, input int unsigned xs);
      int n;
      n = 0;
      wb(1'b1, MR4_OFS, 4'h2, {22'h0, ab, 9'h0});
      mdl.send(C_SRE);
      tick(1);
      check({31'h0, rdy}, 32'h0);
      mdl.send(C_REF);
      tick(8);
      mdl.send(C_SRX);
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 200);
      check({31'h0, n inside {[xs:xs + 3]}}, 32'h1);
      // Normal exit lets the refresh finish; an abort leaves the count
      wb(1'b0, REFCNT_OFS, 4'hF, 32'h0);
      check(rdat, 32'h1);
   endtask
   task automatic t_pd();
      int n;
      n = 0;
      mdl.send(C_PDE);
      tick(9);
      check({31'h0, rdy}, 32'h0);
      mdl.send(C_PDX);
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      check({31'h0, rdy}, 32'h1);
   endtask
   task automatic t_lvl();
      wb(1'b1, MR1_OFS, 4'h1, 32'h81);
      check({16'h0, oe}, 32'hFFFF);
      mdl.strobe(0, 1'b1);
      mdl.strobe(1, 1'b0);
      tick(1);
      check({16'h0, dq}, 32'h00FF);
      mdl.strobe(1, 1'b1);
      tick(1);
      check({16'h0, dq}, 32'hFFFF);
      mdl.set_odt(1'b1);
      tick(2);
      check({30'h0, term}, 32'h2);
      mdl.set_odt(1'b0);
      wb(1'b1, MR1_OFS, 4'h3, 32'h1081);
      check({16'h0, oe}, 32'h0);
      wb(1'b1, MR1_OFS, 4'h3, 32'h1);
      check({dq, oe}, 32'h0);
   endtask
   task automatic print_verdict();
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Free-running 250 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Whole run is under a thousand cycles; this cuts a hang short
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
   initial begin
      rst_i = 1'b1;
      req = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      sel = 4'h0;
      wdat = 32'h0;
      err_total = 0;
      tests_run = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_dll();
      sr_cycle(1'b0, XS_CYC);
      sr_cycle(1'b1, XS_ABORT_CYC);
      t_pd();
      t_lvl();
      print_verdict();
   end
endmodule
